// ---- hw/iwc_map.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the package and the design modules
`ifndef IWC_MAP_SVH
`define IWC_MAP_SVH
// Register indices, four bytes apart
`define IWC_GLOBAL_ADDR   12'h0060
`define IWC_SYS_ADDR      12'h0061
`define IWC_SUP_ADDR      12'h0062
`define IWC_TRX_ADDR      12'h0063
`define IWC_BANK0_ADDR    12'h0064
`define IWC_BANK1_ADDR    12'h0065
`define IWC_SYS_EN_ADDR   12'h0071
`define IWC_SUP_EN_ADDR   12'h0072
`define IWC_TRX_EN_ADDR   12'h0073
`define IWC_BANK0_EN_ADDR 12'h0074
`define IWC_BANK1_EN_ADDR 12'h0075
// Status groups
`define IWC_GROUPS        5
// System group bits
`define IWC_B_WDOG        0
`define IWC_B_SERIAL      1
`define IWC_B_OTEMP       2
`define IWC_B_PWRON       4
`define IWC_B_OVSD        5
// Supply group bits
`define IWC_B_MAINUV      0
`define IWC_B_EXTUV       1
`define IWC_B_EXTOV       2
`define IWC_B_BATUV       3
`define IWC_B_BATOV       4
`define IWC_B_SWCHG       5
// Transceiver group bits
`define IWC_B_CANWAKE     0
`define IWC_B_CANFAULT    1
`define IWC_B_LIN1WAKE    2
`define IWC_B_LIN2WAKE    3
`define IWC_B_CANSIL      4
`define IWC_B_PNERR       5
// Implemented bits, always-enabled bits, priority and regular masks
`define IWC_SYS_MASK      8'h37
`define IWC_SUP_MASK      8'h3F
`define IWC_TRX_MASK      8'h3F
`define IWC_SYS_ALWAYS    8'h31
`define IWC_TRX_ALWAYS    8'h20
`define IWC_SYS_PRIO      8'h24
`define IWC_SUP_PRIO      8'h39
`define IWC_TRX_REGULAR   8'h0D
`define IWC_RST_EN        8'h00
// Delay timer: time in us and cycles at 25 MHz
`define IWC_CLK_MHZ       25
`define IWC_DELAY_US      20
`define IWC_DELAY_CYC     (`IWC_DELAY_US * `IWC_CLK_MHZ)
`endif

// ---- hw/iwc_pkg.sv ----
// Types shared by the interrupt and wake controller
// Assumes iwc_map.svh on the include path
`include "iwc_map.svh"
package iwc_pkg;
   // Event strobes from the surrounding chip, one cycle each
   typedef struct packed {
      logic       wdog_overflow;
      logic       bad_wdog_mode;
      logic       bad_wdog_period;
      logic       bad_mode_code;
      logic       bad_frame_len;
      logic       locked_write;
      logic       otemp;
      logic       pn_error;
      logic       left_off;
      logic       ovsd;
      logic       main_uv;
      logic       ext_uv;
      logic       ext_ov;
      logic       bat_uv;
      logic       bat_ov;
      logic       can_wake;
      logic       lin1_wake;
      logic       lin2_wake;
      logic       can_silence;
      logic [3:0] hv_rise;
      logic [3:0] hv_fall;
      logic [3:0] hv_open;
      logic [3:0] hv_short;
   } iwc_events_t;
   // Level status from the surrounding chip
   typedef struct packed {
      logic       can_supply_state;
      logic       can_fault_state;
      logic       switcher_state;
      logic       main_reg_on;
      logic       can_active;
      logic       lin1_active;
      logic       lin2_active;
      logic [3:0] hv_wake_cfg;
      logic [3:0] hv_drv_on;
   } iwc_status_t;
   // Mode sequencer requests
   typedef enum logic [2:0] {
      IWC_REQ_NONE  = 3'b001,
      IWC_REQ_SLEEP = 3'b010,
      IWC_REQ_RESET = 3'b100
   } iwc_req_t;
endpackage

// ---- hw/iwc_delay_timer.sv ----
// Interrupt delay timer for the main request pin
// Assumes restart as a single-cycle input and stop as a level, both on core_clk_in
`timescale 1ns/1ps
`include "iwc_map.svh"
module iwc_delay_timer (
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   // Control
   input  wire logic restart_in,
   input  wire logic stop_in,
   // Status
   output logic      running_out
);
   localparam int unsigned CYC = `IWC_DELAY_CYC;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   // Reset output low beats a restart; a clear mid-run reloads
   assign count_next = stop_in    ? 16'h0000 :
                       restart_in ? 16'(CYC) :
                       (count_reg != 16'h0000) ? count_reg - 16'h0001 : 16'h0000;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) count_reg <= 16'h0000;
      else        count_reg <= count_next;
   end
   assign running_out = (count_reg != 16'h0000);
endmodule

// ---- hw/iwc_flag_group.sv ----
// One status group: sticky flags, write-one-to-clear, enable gating
// Assumes all inputs on core_clk_in
`timescale 1ns/1ps
module iwc_flag_group (
   // Clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   // Events and gating
   input  wire logic [7:0] event_in,
   input  wire logic [7:0] enable_in,
   input  wire logic [7:0] impl_mask_in,
   // Clear strobe
   input  wire logic       clear_we_in,
   input  wire logic [7:0] clear_bits_in,
   // Flags
   output logic [7:0]      flags_out,
   output logic            cleared_out
);
   logic [7:0] flags_reg;
   logic [7:0] set_w;
   logic [7:0] clr_w;
   // Disabled sources never latch; set wins over a same-cycle clear
   assign set_w = event_in & enable_in & impl_mask_in;
   assign clr_w = clear_we_in ? clear_bits_in : 8'h00;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) flags_reg <= 8'h00;
      else        flags_reg <= (flags_reg & ~clr_w) | set_w;
   end
   assign flags_out   = flags_reg;
   assign cleared_out = |(clr_w & flags_reg);
endmodule

// ---- hw/iwc_top.sv ----
// Interrupt and wake aggregation with AHB-Lite register access
// Assumes event strobes on core_clk_in; the reset-output pin is synchronised here
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "iwc_map.svh"
module iwc_top (
   // Clock and reset
   input  wire logic                core_clk_in,
   input  wire logic                rst_in,
   // AHB-Lite slave
   input  wire logic                hsel_in,
   input  wire logic [11:0]         haddr_in,
   input  wire logic [1:0]          htrans_in,
   input  wire logic                hwrite_in,
   input  wire logic [2:0]          hsize_in,
   input  wire logic [31:0]         hwdata_in,
   input  wire logic                hready_in,
   output logic [31:0]              hrdata_out,
   output logic                     hreadyout_out,
   output logic                     hresp_out,
   // Chip events and status
   input  wire iwc_pkg::iwc_events_t events_in,
   input  wire iwc_pkg::iwc_status_t status_in,
   input  wire logic                sleep_mode_in,
   input  wire logic                reset_out_n_in,
   input  wire logic                sleep_cmd_in,
   // Open-drain request pins, enable high pulls low
   output logic                     irq_main_n_out,
   output logic                     irq_main_oe_out,
   output logic                     irq_priority_n_out,
   output logic                     irq_priority_oe_out,
   // Receive pin pull-downs on bus wake
   output logic                     can_receive_pin_oe_out,
   output logic                     lin1_receive_pin_oe_out,
   output logic                     lin2_receive_pin_oe_out,
   // Mode sequencer requests
   output iwc_pkg::iwc_req_t        mode_req_out,
   output logic                     wake_req_out
);
   localparam int G = `IWC_GROUPS;

   // Reset-output pin crosses from the pad: two flops
   logic reset_out_n_s1_reg;
   logic reset_out_n_s2_reg;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reset_out_n_s1_reg <= 1'b0;
         reset_out_n_s2_reg <= 1'b0;
      end else begin
         reset_out_n_s1_reg <= reset_out_n_in;
         reset_out_n_s2_reg <= reset_out_n_s1_reg;
      end
   end

   // Status edge detect: CAN fault rise and switcher change
   logic can_fault_prev_reg;
   logic sw_prev_reg;
   wire  can_fault_lvl = status_in.can_supply_state | status_in.can_fault_state;
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         can_fault_prev_reg <= 1'b0;
         sw_prev_reg        <= 1'b0;
      end else begin
         can_fault_prev_reg <= can_fault_lvl;
         sw_prev_reg        <= status_in.switcher_state;
      end
   end
   wire can_fault_rise = can_fault_lvl & ~can_fault_prev_reg;
   wire sw_change      = status_in.switcher_state ^ sw_prev_reg;

   // Raw event vectors per group
   logic [7:0] ev_w [G];
   wire serial_fault = events_in.bad_wdog_mode | events_in.bad_wdog_period |
                       events_in.bad_mode_code | events_in.bad_frame_len |
                       events_in.locked_write;
   assign ev_w[0] = {2'b00, events_in.ovsd, events_in.left_off, 1'b0,
                     events_in.otemp, serial_fault, events_in.wdog_overflow};
   assign ev_w[1] = {2'b00, sw_change, events_in.bat_ov, events_in.bat_uv,
                     events_in.ext_ov, events_in.ext_uv,
                     events_in.main_uv & status_in.main_reg_on & ~sleep_mode_in};
   assign ev_w[2] = {2'b00, events_in.pn_error, events_in.can_silence,
                     events_in.lin2_wake & ~status_in.lin2_active,
                     events_in.lin1_wake & ~status_in.lin1_active,
                     can_fault_rise,
                     events_in.can_wake & ~status_in.can_active};
   assign ev_w[3] = {events_in.hv_fall[3], events_in.hv_rise[3],
                     events_in.hv_fall[2], events_in.hv_rise[2],
                     events_in.hv_fall[1], events_in.hv_rise[1],
                     events_in.hv_fall[0], events_in.hv_rise[0]}
                    & {{2{status_in.hv_wake_cfg[3]}}, {2{status_in.hv_wake_cfg[2]}},
                       {2{status_in.hv_wake_cfg[1]}}, {2{status_in.hv_wake_cfg[0]}}};
   assign ev_w[4] = {events_in.hv_short[3], events_in.hv_open[3],
                     events_in.hv_short[2], events_in.hv_open[2],
                     events_in.hv_short[1], events_in.hv_open[1],
                     events_in.hv_short[0], events_in.hv_open[0]}
                    & {{2{status_in.hv_drv_on[3]}}, {2{status_in.hv_drv_on[2]}},
                       {2{status_in.hv_drv_on[1]}}, {2{status_in.hv_drv_on[0]}}};

   // Implemented bits, always-on bits, priority and regular classes
   logic [7:0] mask_w [G];
   logic [7:0] always_w [G];
   logic [7:0] prio_w [G];
   logic [7:0] regular_w [G];
   assign mask_w[0] = `IWC_SYS_MASK;
   assign mask_w[1] = `IWC_SUP_MASK;
   assign mask_w[2] = `IWC_TRX_MASK;
   assign mask_w[3] = 8'hFF;
   assign mask_w[4] = 8'hFF;
   assign always_w[0] = `IWC_SYS_ALWAYS;
   assign always_w[1] = 8'h00;
   assign always_w[2] = `IWC_TRX_ALWAYS;
   assign always_w[3] = 8'h00;
   assign always_w[4] = 8'h00;
   assign prio_w[0] = `IWC_SYS_PRIO;
   assign prio_w[1] = `IWC_SUP_PRIO;
   assign prio_w[2] = 8'h00;
   assign prio_w[3] = 8'h00;
   assign prio_w[4] = 8'h00;
   assign regular_w[0] = 8'h00;
   assign regular_w[1] = 8'h00;
   assign regular_w[2] = `IWC_TRX_REGULAR;
   assign regular_w[3] = 8'hFF;
   assign regular_w[4] = 8'h00;

   // AHB-Lite address phase capture; zero-wait slave
   logic        wr_pend_reg;
   logic [11:0] addr_reg;
   wire         take = hsel_in & hready_in & htrans_in[1];
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
      end else begin
         wr_pend_reg <= take & hwrite_in;
         addr_reg    <= take ? haddr_in : addr_reg;
      end
   end
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   wire   [11:0] idx_w  = {2'b00, addr_reg[11:2]};                    // Byte address over four

   // Enable registers, software written
   logic [7:0] en_reg [G];
   logic [7:0] flags_w [G];
   logic [G-1:0] cleared_w;
   logic [G-1:0] any_w;
   logic [G-1:0] prio_any_w;
   logic [G-1:0] reg_en_w;
   logic [G-1:0] st_hit_w;
   logic [G-1:0] en_hit_w;
   wire  [11:0] st_base [G] = '{`IWC_SYS_ADDR, `IWC_SUP_ADDR, `IWC_TRX_ADDR,
                                `IWC_BANK0_ADDR, `IWC_BANK1_ADDR};
   wire  [11:0] en_base [G] = '{`IWC_SYS_EN_ADDR, `IWC_SUP_EN_ADDR, `IWC_TRX_EN_ADDR,
                                `IWC_BANK0_EN_ADDR, `IWC_BANK1_EN_ADDR};

   // Per-group flags, enables and decode
   for (genvar g = 0; g < G; g++) begin : grp
      assign st_hit_w[g] = (idx_w == st_base[g]);
      assign en_hit_w[g] = (idx_w == en_base[g]);
      always_ff @(posedge core_clk_in or posedge rst_in) begin
         if (rst_in) en_reg[g] <= `IWC_RST_EN;
         else if (wr_pend_reg & en_hit_w[g]) en_reg[g] <= hwdata_in[7:0] & mask_w[g];
      end
      iwc_flag_group u_flags (
         .core_clk_in   (core_clk_in),
         .rst_in        (rst_in),
         .event_in      (ev_w[g]),
         .enable_in     (en_reg[g] | always_w[g]),
         .impl_mask_in  (mask_w[g]),
         .clear_we_in   (wr_pend_reg & st_hit_w[g]),
         .clear_bits_in (hwdata_in[7:0]),
         .flags_out     (flags_w[g]),
         .cleared_out   (cleared_w[g])
      );
      assign any_w[g]      = |flags_w[g];
      assign prio_any_w[g] = |(flags_w[g] & prio_w[g]);
      assign reg_en_w[g]   = |(en_reg[g] & regular_w[g]);
   end

   // Read mux, combinational on the address captured for the data phase
   wire global_hit = (idx_w == `IWC_GLOBAL_ADDR);
   logic [7:0] rd_w;
   always_comb begin
      rd_w = global_hit ? {3'b000, any_w} : 8'h00;
      for (int i = 0; i < G; i++) begin
         if (st_hit_w[i]) rd_w = flags_w[i];
         if (en_hit_w[i]) rd_w = en_reg[i];
      end
   end
   assign hrdata_out = {24'h000000, rd_w};

   // Summaries
   wire any_pending = |any_w;
   wire any_cleared = |cleared_w;
   wire prio_pend   = |prio_any_w;
   wire any_reg_en  = |reg_en_w;

   // Delay timer on the main request pin only
   logic timer_run;
   iwc_delay_timer u_timer (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .restart_in  (any_cleared),
      .stop_in     (~reset_out_n_s2_reg),
      .running_out (timer_run)
   );

   // Request pins, registered; main freed on any clear and while the delay runs, priority freed when its flags clear
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_main_oe_out     <= 1'b0;
         irq_priority_oe_out <= 1'b0;
      end else begin
         irq_main_oe_out     <= any_pending & ~timer_run & ~any_cleared;
         irq_priority_oe_out <= prio_pend;
      end
   end
   assign irq_main_n_out     = 1'b0;
   assign irq_priority_n_out = 1'b0;

   // Receive pins held low while the matching wake flag pends
   assign can_receive_pin_oe_out  = flags_w[2][`IWC_B_CANWAKE];
   assign lin1_receive_pin_oe_out = flags_w[2][`IWC_B_LIN1WAKE];
   assign lin2_receive_pin_oe_out = flags_w[2][`IWC_B_LIN2WAKE];

   // Sleep protection and wake; second watchdog overflow forces reset
   wire wdog_again = events_in.wdog_overflow & flags_w[0][`IWC_B_WDOG];
   iwc_pkg::iwc_req_t req_next;
   always_comb begin
      req_next = iwc_pkg::IWC_REQ_NONE;
      if (wdog_again) req_next = iwc_pkg::IWC_REQ_RESET;
      else if (sleep_cmd_in) begin
         if (any_pending | ~any_reg_en) req_next = iwc_pkg::IWC_REQ_RESET;
         else req_next = iwc_pkg::IWC_REQ_SLEEP;
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_req_out <= iwc_pkg::IWC_REQ_NONE;
         wake_req_out <= 1'b0;
      end else begin
         mode_req_out <= req_next;
         wake_req_out <= sleep_mode_in & any_pending;
      end
   end
endmodule

// ---- verification/iwc_host_model.sv ----
// Host side of the two open-drain request lines, with board pull-ups
// Assumes oe high while the device pulls a line low
`timescale 1ns/1ps
module iwc_host_model (
   // Device drives
   input  wire logic main_n_in,
   input  wire logic main_oe_in,
   input  wire logic prio_n_in,
   input  wire logic prio_oe_in,
   // Line levels seen by the host
   output logic      main_lvl_out,
   output logic      prio_lvl_out
);
   // Released line reads the pull-up
   assign main_lvl_out = main_oe_in ? main_n_in : 1'b1;
   assign prio_lvl_out = prio_oe_in ? prio_n_in : 1'b1;
endmodule

// ---- verification/iwc_top_assertions.sv ----
// Port checker for the interrupt and wake controller
// Assumes bind to iwc_top; byte address is register index times four
`timescale 1ns/1ps
`include "iwc_map.svh"
module iwc_top_assertions (
   // Clock and reset
   input wire logic                 core_clk_in,
   input wire logic                 rst_in,
   // Bus
   input wire logic                 hsel_in,
   input wire logic [11:0]          haddr_in,
   input wire logic [1:0]           htrans_in,
   input wire logic                 hwrite_in,
   input wire logic                 hready_in,
   input wire logic [31:0]          hwdata_in,
   input wire logic                 hreadyout_out,
   input wire logic                 hresp_out,
   // Chip side
   input wire iwc_pkg::iwc_events_t events_in,
   input wire iwc_pkg::iwc_status_t status_in,
   input wire logic                 sleep_mode_in,
   input wire logic                 reset_out_n_in,
   input wire logic                 sleep_cmd_in,
   input wire logic                 irq_main_oe_out,
   input wire logic                 irq_priority_oe_out,
   input wire logic                 can_receive_pin_oe_out,
   input wire iwc_pkg::iwc_req_t    mode_req_out,
   input wire logic                 wake_req_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   logic       st_dp_reg;
   logic [9:0] since_reg;
   // Status word write seen in its address phase
   wire [11:0] idx        = {2'b00, haddr_in[11:2]};
   wire        st_ap      = hsel_in && hready_in && htrans_in[1] && hwrite_in &&
                            idx >= `IWC_SYS_ADDR && idx <= `IWC_BANK1_ADDR;
   wire        clr_now    = st_dp_reg && hwdata_in[7:0] != 8'h00;
   // Stopped timer counts as expired, so saturate while reset output is low
   wire [9:0]  since_next = !reset_out_n_in ? 10'h3FF : clr_now ? 10'h000 :
                            (since_reg == 10'h3FF) ? since_reg : since_reg + 10'h001;
   // Cycles since the last flag clear
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_dp_reg <= 1'b0;
         since_reg <= 10'h3FF;
      end else begin
         st_dp_reg <= st_ap;
         since_reg <= since_next;
      end
   end
   sequence s_cleared;
      $past(clr_now) || $past(clr_now, 2);
   endsequence
   sequence s_req_any;
      ##[1:2] mode_req_out != iwc_pkg::IWC_REQ_NONE;
   endsequence
   AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
      else $error("bus answer not okay");
   AST_PRIO_NOW: assert property (events_in.ovsd |-> ##[1:2] irq_priority_oe_out)
      else $error("priority line late");
   AST_MAIN_FALL: assert property ($fell(irq_main_oe_out) |-> s_cleared)
      else $error("main freed without clear");
   AST_PRIO_FALL: assert property ($fell(irq_priority_oe_out) |-> s_cleared)
      else $error("prio freed without clear");
   AST_DELAY_HOLD: assert property ($rose(irq_main_oe_out) |-> since_reg >= 10'd490)
      else $error("main line pulled early");
   AST_RX_FALL: assert property ($fell(can_receive_pin_oe_out) |-> s_cleared)
      else $error("rx freed without clear");
   AST_RX_ACTIVE: assert property (events_in.can_wake && status_in.can_active &&
      !can_receive_pin_oe_out |=> !can_receive_pin_oe_out)
      else $error("wake taken while active");
   AST_SLEEP_ANS: assert property (sleep_cmd_in |-> s_req_any)
      else $error("sleep unanswered");
   AST_SLEEP_BLOCK: assert property (sleep_cmd_in && irq_main_oe_out |->
      ##[1:2] mode_req_out == iwc_pkg::IWC_REQ_RESET)
      else $error("sleep allowed while pending");
   AST_REQ_CAUSE: assert property (mode_req_out == iwc_pkg::IWC_REQ_SLEEP |->
      $past(sleep_cmd_in) || $past(sleep_cmd_in, 2))
      else $error("sleep without command");
   AST_WAKE: assert property (sleep_mode_in && irq_main_oe_out |-> ##[0:2] wake_req_out)
      else $error("no wake from sleep");
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the interrupt and wake controller
// Assumes one AHB-Lite master and the host pull-up model
`timescale 1ns/1ps
`include "iwc_map.svh"
module tb_top;
   logic                 clk, rst, hsel, hwrite, rsto_n, slp_cmd, slp_mode, hresp;
   logic                 hrdy, m_oe, p_oe, m_n, p_n, m_lvl, p_lvl, c_oe, l1_oe, l2_oe, wake;
   logic [11:0]          haddr;
   logic [1:0]           htrans;
   logic [2:0]           hsize;
   logic [31:0]          hwdata, hrdata, rd;
   iwc_pkg::iwc_events_t ev;
   iwc_pkg::iwc_status_t st;
   iwc_pkg::iwc_req_t    req, seen;
   int                   bad_count, total_checks, cyc, c0;
   iwc_top i_dut (
      .core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .events_in(ev), .status_in(st), .sleep_mode_in(slp_mode), .reset_out_n_in(rsto_n),
      .sleep_cmd_in(slp_cmd), .irq_main_n_out(m_n), .irq_main_oe_out(m_oe),
      .irq_priority_n_out(p_n), .irq_priority_oe_out(p_oe),
      .can_receive_pin_oe_out(c_oe), .lin1_receive_pin_oe_out(l1_oe),
      .lin2_receive_pin_oe_out(l2_oe), .mode_req_out(req), .wake_req_out(wake));
   iwc_host_model i_host (
      .main_n_in(m_n), .main_oe_in(m_oe), .prio_n_in(p_n), .prio_oe_in(p_oe),
      .main_lvl_out(m_lvl), .prio_lvl_out(p_lvl));
   // Clock, cycles, one-cycle mode request capture
   always #20 clk = !clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (req != iwc_pkg::IWC_REQ_NONE) seen <= req;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait for hready high
   task automatic hwait();
      int i = 0;
      @(posedge clk);
      while (hrdy !== 1'b1) begin
         i++;
         if (i > 20) begin
            bad_count++;
            finish_test();
         end
         @(posedge clk);
      end
   endtask
   // Single word transfer; read data taken at data edge
   task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {idx[9:0], 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      hwait();
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      hwait();
      rd = hrdata;
   endtask
   task automatic rdc(input string n, input logic [11:0] idx, input logic [31:0] e);
      xfer(1'b0, idx, 32'h0000_0000);
      chk_reg(n, e, rd);
   endtask
   // Ends the caller's strobe, lets pins settle
   task automatic strobe();
      @(posedge clk);
      ev <= '0;
      tick(2);
   endtask
   task automatic sleep_req(input iwc_pkg::iwc_req_t e);
      slp_cmd <= 1'b1;
      @(posedge clk);
      slp_cmd <= 1'b0;
      tick(3);
      chk_reg("mode request", 32'(e), 32'(seen));
      seen <= iwc_pkg::IWC_REQ_NONE;
   endtask
   // Bounded wait for main line low
   task automatic wait_main();
      int i;
      for (i = 0; i < 1000 && m_lvl !== 1'b0; i++) @(posedge clk);
      if (i == 1000) begin
         bad_count++;
         finish_test();
      end
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {hsel, hwrite, slp_cmd, slp_mode} = 4'h0;
      {haddr, htrans, hwdata} = '0;
      hsize = 3'b010;
      ev = '0;
      st = '0;
      st.main_reg_on = 1'b1;
      rsto_n = 1'b1;
      seen = iwc_pkg::IWC_REQ_NONE;
      {bad_count, total_checks, cyc} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      // Reset values; unmapped word ignored
      xfer(1'b1, 12'h007F, 32'h0000_00FF);
      for (int a = 'h60; a <= 'h7F; a++) rdc("reset value", a[11:0], 32'h0000_0000);
      // Always-enabled priority source, zero write, one write
      ev.ovsd <= 1'b1;
      strobe();
      chk_bit("prio line", 1'b0, p_lvl);
      chk_bit("main line", 1'b0, m_lvl);
      rdc("global", `IWC_GLOBAL_ADDR, 32'h0000_0001);
      xfer(1'b1, `IWC_SYS_ADDR, 32'h0000_0000);
      rdc("zero write", `IWC_SYS_ADDR, 32'h0000_0020);
      xfer(1'b1, `IWC_SYS_ADDR, 32'h0000_0020);
      tick(2);
      chk_bit("main free", 1'b1, m_lvl);
      chk_bit("prio free", 1'b1, p_lvl);
      // Flags captured while the delay runs; a clear restarts it
      ev.left_off <= 1'b1;
      strobe();
      ev.wdog_overflow <= 1'b1;
      strobe();
      rdc("during delay", `IWC_SYS_ADDR, 32'h0000_0011);
      chk_bit("main held", 1'b1, m_lvl);
      tick(300);
      xfer(1'b1, `IWC_SYS_ADDR, 32'h0000_0001);
      c0 = cyc;
      wait_main();
      chk_bit("delay length", 1'b1, cyc - c0 >= 495 && cyc - c0 <= 505);
      slp_mode <= 1'b1;
      tick(3);
      chk_bit("wake request", 1'b1, wake);
      slp_mode <= 1'b0;
      sleep_req(iwc_pkg::IWC_REQ_RESET);
      // Second overflow with flag pending, then a two-bit clear
      ev.wdog_overflow <= 1'b1;
      strobe();
      ev.wdog_overflow <= 1'b1;
      strobe();
      chk_reg("overflow again", 32'(iwc_pkg::IWC_REQ_RESET), 32'(seen));
      seen <= iwc_pkg::IWC_REQ_NONE;
      xfer(1'b1, `IWC_SYS_ADDR, 32'h0000_0011);
      rdc("multi clear", `IWC_GLOBAL_ADDR, 32'h0000_0000);
      // Sleep guard with no regular enable, then with one
      sleep_req(iwc_pkg::IWC_REQ_RESET);
      xfer(1'b1, `IWC_TRX_EN_ADDR, 32'h0000_00FF);
      xfer(1'b1, `IWC_SUP_EN_ADDR, 32'h0000_00FF);
      xfer(1'b1, `IWC_SYS_EN_ADDR, 32'h0000_00FF);
      sleep_req(iwc_pkg::IWC_REQ_SLEEP);
      ev.ext_uv <= 1'b1;
      strobe();
      sleep_req(iwc_pkg::IWC_REQ_RESET);
      xfer(1'b1, `IWC_SUP_ADDR, 32'h0000_0002);
      // Bus wakes: ignored while active, receive pins held until cleared
      st.can_active <= 1'b1;
      ev.can_wake <= 1'b1;
      strobe();
      rdc("active wake", `IWC_TRX_ADDR, 32'h0000_0000);
      st.can_active <= 1'b0;
      ev.can_wake <= 1'b1;
      ev.lin1_wake <= 1'b1;
      strobe();
      rdc("bus wakes", `IWC_TRX_ADDR, 32'h0000_0005);
      chk_bit("can rx low", 1'b1, c_oe);
      xfer(1'b1, `IWC_TRX_ADDR, 32'h0000_0001);
      tick(1);
      chk_bit("can rx free", 1'b0, c_oe);
      chk_bit("lin rx held", 1'b1, l1_oe);
      xfer(1'b1, `IWC_TRX_ADDR, 32'h0000_0004);
      // Supply sources and CAN fault state
      st.main_reg_on <= 1'b0;
      ev.main_uv <= 1'b1;
      strobe();
      rdc("uv regulator off", `IWC_SUP_ADDR, 32'h0000_0000);
      st.main_reg_on <= 1'b1;
      ev.main_uv <= 1'b1;
      st.switcher_state <= 1'b1;
      strobe();
      chk_bit("uv prio", 1'b0, p_lvl);
      rdc("uv and switch", `IWC_SUP_ADDR, 32'h0000_0021);
      xfer(1'b1, `IWC_SUP_ADDR, 32'h0000_0021);
      st.switcher_state <= 1'b0;
      st.can_supply_state <= 1'b1;
      tick(2);
      rdc("switch fall", `IWC_SUP_ADDR, 32'h0000_0020);
      rdc("can fault", `IWC_TRX_ADDR, 32'h0000_0002);
      xfer(1'b1, `IWC_SUP_ADDR, 32'h0000_0020);
      xfer(1'b1, `IWC_TRX_ADDR, 32'h0000_0002);
      // Every serial fault cause
      for (int k = 0; k < 5; k++) begin
         ev[$bits(ev) - 2 - k] <= 1'b1;
         strobe();
         rdc("serial fault", `IWC_SYS_ADDR, 32'h0000_0002);
         xfer(1'b1, `IWC_SYS_ADDR, 32'h0000_0002);
      end
      // Reset output low stops the running delay
      rsto_n <= 1'b0;
      c0 = cyc;
      ev.otemp <= 1'b1;
      strobe();
      wait_main();
      chk_bit("delay stopped", 1'b1, cyc - c0 < 10);
      rsto_n <= 1'b1;
      xfer(1'b1, `IWC_SYS_ADDR, 32'h0000_0004);
      rdc("all clear", `IWC_GLOBAL_ADDR, 32'h0000_0000);
      finish_test();
   end
endmodule
bind iwc_top iwc_top_assertions i_chk (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
   .hwdata_in(hwdata_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .events_in(events_in), .status_in(status_in), .sleep_mode_in(sleep_mode_in),
   .reset_out_n_in(reset_out_n_in), .sleep_cmd_in(sleep_cmd_in),
   .irq_main_oe_out(irq_main_oe_out), .irq_priority_oe_out(irq_priority_oe_out),
   .can_receive_pin_oe_out(can_receive_pin_oe_out), .mode_req_out(mode_req_out),
   .wake_req_out(wake_req_out));
